/* pkg/pef_pkg.sv */
// Register map, field positions, reset values and timing for the event flag block
package pef_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_INT_TOP  = 8'h00;
   localparam logic [7:0] ADDR_INT_BUCK = 8'h04;
   localparam logic [7:0] ADDR_INT_LIN  = 8'h08;
   localparam logic [7:0] ADDR_MSK_TOP  = 8'h0c;
   localparam logic [7:0] ADDR_MSK_BUCK = 8'h10;
   localparam logic [7:0] ADDR_MSK_LIN  = 8'h14;
   localparam logic [7:0] ADDR_STAT     = 8'h18;
   localparam logic [7:0] ADDR_CTRL     = 8'h1c;
   // Top flag and top mask bit positions
   localparam int TOP_HOT     = 0;
   localparam int TOP_TRIP    = 1;
   localparam int TOP_OVP     = 2;
   localparam int TOP_OKDROP  = 3;
   localparam int TOP_SYNC    = 4;
   localparam int TOP_MEAS    = 5;
   localparam int TOP_RST     = 6;
   localparam int TOP_BUCKSUM = 7;
   localparam int TOP_LINSUM  = 8;
   localparam logic [6:0] TOP_MASK_WR = 7'h39;
   // Per-group flag and mask layout: two regulators per field
   localparam int GRP_CL   = 0;
   localparam int GRP_SC   = 2;
   localparam int GRP_PG   = 4;
   localparam int GRP_RISE = 2;
   localparam int GRP_FALL = 4;
   // Control register bits
   localparam int CTRL_SWRST  = 0;
   localparam int CTRL_POL    = 1;
   localparam int CTRL_DET    = 2;
   localparam int CTRL_BUCKEN = 4;
   localparam int CTRL_LINEN  = 6;
   localparam int CTRL_GPA    = 8;
   localparam int CTRL_GPB    = 9;
   // Status register bits
   localparam int ST_HOT    = 0;
   localparam int ST_TRIP   = 1;
   localparam int ST_OVP    = 2;
   localparam int ST_OK     = 3;
   localparam int ST_SYNC   = 4;
   localparam int ST_BUCKCL = 5;
   localparam int ST_LINCL  = 7;
   localparam int ST_BUCKPG = 9;
   localparam int ST_LINPG  = 11;
   // Reset values
   localparam logic [6:0]  TOP_MASK_RST = 7'h00;
   localparam logic [5:0]  GRP_MASK_RST = 6'h00;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   // Short-circuit check time and debounce
   localparam int CLK_PERIOD_NS = 100;
   localparam int SC_TIME_MS    = 1;
   localparam int SC_CYCLES     = SC_TIME_MS * 1000000 / CLK_PERIOD_NS;
   // Bus slave states
   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b01,
      BUS_ACCESS = 2'b10
   } pef_bus_e;
endpackage

/* rtl/pef_event_flags.sv */
// Event flags, masks, status and protective responses behind an AHB-Lite slave
`timescale 1ns/1ps
module pef_event_flags import pef_pkg::*; #(
   parameter int SC_CNT    = SC_CYCLES,
   parameter int SC_W      = 16
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Regulator monitors, index 0 and 1
   input  wire logic [1:0]  buck_curlim_hit,
   input  wire logic [1:0]  lin_curlim_hit,
   input  wire logic [1:0]  buck_vout_low,
   input  wire logic [1:0]  lin_vout_low,
   input  wire logic [1:0]  buck_good_in,
   input  wire logic [1:0]  lin_good_in,
   // Device monitors
   input  wire logic        hot_warning_in,
   input  wire logic        thermal_trip_in,
   input  wire logic        input_overvolt_in,
   input  wire logic        supply_low_lockout,
   input  wire logic        supplies_ok_valid,
   input  wire logic        sync_clk_present,
   input  wire logic        load_meas_done,
   input  wire logic        otp_reset_mask,
   // Regulator and output controls
   output logic      [1:0]  buck_enable,
   output logic      [1:0]  lin_enable,
   output logic             gp_out_a,
   output logic             gp_out_b,
   output logic             supplies_ok_pin,
   // Open-drain interrupt pin
   input  wire logic        irq_out_n_i,
   output logic             irq_out_n_o,
   output logic             irq_out_n_oe
);

   typedef struct packed {
      pef_bus_e             st;
      logic [7:0]           addr;
      logic                 wr;
      logic                 hreadyout;
      logic [31:0]          hrdata;
      logic [6:0]           top_flag;
      logic [6:0]           top_mask;
      logic [1:0][5:0]      grp_flag;
      logic [1:0][5:0]      grp_mask;
      logic [1:0][1:0]      good_prev;
      logic                 ok_prev;
      logic                 sync_prev;
      logic                 pol;
      logic                 det_en;
      logic [1:0][1:0]      reg_en;
      logic                 gpa;
      logic                 gpb;
      logic [3:0]           sc_started;
      logic [3:0][SC_W-1:0] sc_cnt;
      logic                 por_pend;
      logic                 irq_oe;
      logic                 pin;
   } pef_state_s;

   pef_state_s      s_q;
   pef_state_s      s_d;
   pef_state_s      keep_s;
   logic            access;
   logic            swrst_wr;
   logic [6:0]      clr_top;
   logic [1:0][5:0] clr_grp;
   logic [1:0][1:0] cl_hit;
   logic [1:0][1:0] vlow;
   logic [1:0][1:0] good;
   logic [3:0]      trip;
   logic [31:0]     stat_w;
   logic            pend;
   logic            kill;

   // Next-state logic for bus, flags, protections and resets
   always_comb begin
      s_d      = s_q;
      keep_s   = s_q;
      access   = (s_q.st == BUS_ACCESS);
      swrst_wr = 1'b0;
      clr_top  = '0;
      clr_grp  = '0;
      trip     = '0;
      pend     = 1'b0;
      kill     = thermal_trip_in | input_overvolt_in;
      cl_hit   = {lin_curlim_hit, buck_curlim_hit};
      vlow     = {lin_vout_low, buck_vout_low};
      good     = {lin_good_in, buck_good_in};
      stat_w   = '0;
      stat_w[ST_HOT]  = hot_warning_in;
      stat_w[ST_TRIP] = thermal_trip_in;
      stat_w[ST_OVP]  = input_overvolt_in;
      stat_w[ST_OK]   = supplies_ok_valid;
      stat_w[ST_SYNC] = sync_clk_present;
      stat_w[ST_BUCKCL +: 2] = buck_curlim_hit;
      stat_w[ST_LINCL +: 2]  = lin_curlim_hit;
      stat_w[ST_BUCKPG +: 2] = buck_good_in;
      stat_w[ST_LINPG +: 2]  = lin_good_in;

      // Bus slave: one wait state so read data comes from a flop
      case (s_q.st)
         BUS_IDLE: begin
            s_d.hreadyout = 1'b1;
            if (hsel && htrans[1] && hready) begin
               s_d.st        = BUS_ACCESS;
               s_d.addr      = haddr[7:0];
               s_d.wr        = hwrite;
               s_d.hreadyout = 1'b0;
            end
         end
         BUS_ACCESS: begin
            s_d.st        = BUS_IDLE;
            s_d.hreadyout = 1'b1;
            s_d.hrdata    = '0;
         end
         default: begin
            s_d.st        = BUS_IDLE;
            s_d.hreadyout = 1'b1;
         end
      endcase

      // Read mux; unmapped addresses read zero
      if (access && !s_q.wr) begin
         if (s_q.addr == ADDR_INT_TOP) begin
            s_d.hrdata[6:0]         = s_q.top_flag;
            s_d.hrdata[TOP_BUCKSUM] = |s_q.grp_flag[0];
            s_d.hrdata[TOP_LINSUM]  = |s_q.grp_flag[1];
         end else if (s_q.addr == ADDR_INT_BUCK) begin
            s_d.hrdata[5:0] = s_q.grp_flag[0];
         end else if (s_q.addr == ADDR_INT_LIN) begin
            s_d.hrdata[5:0] = s_q.grp_flag[1];
         end else if (s_q.addr == ADDR_MSK_TOP) begin
            s_d.hrdata[6:0] = s_q.top_mask;
         end else if (s_q.addr == ADDR_MSK_BUCK) begin
            s_d.hrdata[5:0] = s_q.grp_mask[0];
         end else if (s_q.addr == ADDR_MSK_LIN) begin
            s_d.hrdata[5:0] = s_q.grp_mask[1];
         end else if (s_q.addr == ADDR_STAT) begin
            s_d.hrdata = stat_w;
         end else if (s_q.addr == ADDR_CTRL) begin
            // Soft reset bit always reads back zero
            s_d.hrdata[CTRL_POL]             = s_q.pol;
            s_d.hrdata[CTRL_DET]             = s_q.det_en;
            s_d.hrdata[CTRL_BUCKEN +: 2]     = s_q.reg_en[0];
            s_d.hrdata[CTRL_LINEN +: 2]      = s_q.reg_en[1];
            s_d.hrdata[CTRL_GPA]             = s_q.gpa;
            s_d.hrdata[CTRL_GPB]             = s_q.gpb;
         end
      end

      // Write decode; the trip, overvoltage and reset-flag mask bits are not writable
      if (access && s_q.wr) begin
         if (s_q.addr == ADDR_INT_TOP) begin
            clr_top = hwdata[6:0];
         end else if (s_q.addr == ADDR_INT_BUCK) begin
            clr_grp[0] = hwdata[5:0];
         end else if (s_q.addr == ADDR_INT_LIN) begin
            clr_grp[1] = hwdata[5:0];
         end else if (s_q.addr == ADDR_MSK_TOP) begin
            s_d.top_mask = (hwdata[6:0] & TOP_MASK_WR) | (s_q.top_mask & ~TOP_MASK_WR);
         end else if (s_q.addr == ADDR_MSK_BUCK) begin
            s_d.grp_mask[0] = hwdata[5:0];
         end else if (s_q.addr == ADDR_MSK_LIN) begin
            s_d.grp_mask[1] = hwdata[5:0];
         end else if (s_q.addr == ADDR_CTRL) begin
            swrst_wr      = hwdata[CTRL_SWRST];
            s_d.pol       = hwdata[CTRL_POL];
            s_d.det_en    = hwdata[CTRL_DET];
            s_d.reg_en[0] = hwdata[CTRL_BUCKEN +: 2];
            s_d.reg_en[1] = hwdata[CTRL_LINEN +: 2];
            s_d.gpa       = hwdata[CTRL_GPA];
            s_d.gpb       = hwdata[CTRL_GPB];
         end
      end

      // Short-circuit timers: startup check, then low-output debounce
      for (int k = 0; k < 4; k++) begin
         if (!s_q.reg_en[k/2][k%2]) begin
            s_d.sc_cnt[k]     = '0;
            s_d.sc_started[k] = 1'b0;
         end else if (!s_q.sc_started[k] || vlow[k/2][k%2]) begin
            if (s_q.sc_cnt[k] == SC_W'(SC_CNT - 1)) begin
               s_d.sc_cnt[k]     = '0;
               s_d.sc_started[k] = 1'b1;
               trip[k]           = vlow[k/2][k%2];
            end else begin
               s_d.sc_cnt[k] = s_q.sc_cnt[k] + SC_W'(1);
            end
         end else begin
            s_d.sc_cnt[k] = '0;
         end
      end

      // Per-regulator flags; set wins over a same-cycle clear
      for (int g = 0; g < 2; g++) begin
         for (int i = 0; i < 2; i++) begin
            s_d.grp_flag[g][GRP_CL+i] = (s_q.grp_flag[g][GRP_CL+i]
               & ~(clr_grp[g][GRP_CL+i] & ~cl_hit[g][i]))
               | (cl_hit[g][i] & ~s_q.grp_mask[g][GRP_CL+i]);
            s_d.grp_flag[g][GRP_SC+i] = (s_q.grp_flag[g][GRP_SC+i]
               & ~clr_grp[g][GRP_SC+i]) | trip[g*2+i];
            if (trip[g*2+i]) begin
               s_d.reg_en[g][i] = 1'b0;
            end
            s_d.grp_flag[g][GRP_PG+i] = (s_q.grp_flag[g][GRP_PG+i]
               & ~clr_grp[g][GRP_PG+i])
               | (good[g][i] & ~s_q.good_prev[g][i] & ~s_q.grp_mask[g][GRP_RISE+i])
               | (~good[g][i] & s_q.good_prev[g][i]
                  & ~s_q.grp_mask[g][GRP_FALL+i]);
            s_d.good_prev[g][i] = good[g][i];
         end
      end

      // Device-level flags; hot, trip and overvoltage clears refused while the cause stays
      s_d.top_flag[TOP_HOT] = (s_q.top_flag[TOP_HOT] & ~(clr_top[TOP_HOT] & ~hot_warning_in))
         | (hot_warning_in & ~s_q.top_mask[TOP_HOT]);
      s_d.top_flag[TOP_TRIP] = (s_q.top_flag[TOP_TRIP]
         & ~(clr_top[TOP_TRIP] & ~thermal_trip_in)) | thermal_trip_in;
      s_d.top_flag[TOP_OVP] = (s_q.top_flag[TOP_OVP]
         & ~(clr_top[TOP_OVP] & ~input_overvolt_in)) | input_overvolt_in;
      s_d.top_flag[TOP_OKDROP] = (s_q.top_flag[TOP_OKDROP] & ~clr_top[TOP_OKDROP])
         | (s_q.ok_prev & ~supplies_ok_valid & ~s_q.top_mask[TOP_OKDROP]);
      s_d.top_flag[TOP_SYNC] = (s_q.top_flag[TOP_SYNC] & ~clr_top[TOP_SYNC])
         | (((s_q.sync_prev ^ sync_clk_present)
         | (s_q.det_en & ~sync_clk_present)) & ~s_q.top_mask[TOP_SYNC]);
      s_d.top_flag[TOP_MEAS] = (s_q.top_flag[TOP_MEAS] & ~clr_top[TOP_MEAS])
         | (load_meas_done & ~s_q.top_mask[TOP_MEAS]);
      s_d.top_flag[TOP_RST] = s_q.top_flag[TOP_RST] & ~clr_top[TOP_RST];
      s_d.ok_prev   = supplies_ok_valid;
      s_d.sync_prev = sync_clk_present;

      // Faults override software enables at once
      if (kill) begin
         s_d.reg_en = '0;
         s_d.gpa    = 1'b0;
         s_d.gpb    = 1'b0;
      end

      // Start-up after reset: reset mask from one-time memory
      if (s_q.por_pend) begin
         s_d.por_pend          = 1'b0;
         s_d.top_mask[TOP_RST] = otp_reset_mask;
         s_d.top_flag[TOP_RST] = ~otp_reset_mask;
      end

      // Keep the bus fields computed this cycle, not the registered ones.
      // Otherwise the reset write would replay and stall the bus.
      keep_s = s_d;
      // Lockout or soft reset: defaults everywhere except the bus slave
      if (supply_low_lockout || swrst_wr) begin
         s_d           = '0;
         s_d.top_mask  = TOP_MASK_RST;
         s_d.grp_mask  = {GRP_MASK_RST, GRP_MASK_RST};
         s_d.pol       = CTRL_RST[CTRL_POL];
         s_d.st        = keep_s.st;
         s_d.addr      = keep_s.addr;
         s_d.wr        = keep_s.wr;
         s_d.hreadyout = keep_s.hreadyout;
         s_d.hrdata    = keep_s.hrdata;
         s_d.por_pend  = 1'b1;
      end
      if (!s_d.st[0] && !s_d.st[1]) begin
         s_d.st = BUS_IDLE;
      end

      // Interrupt pin and supplies-ok pin from the next state
      pend = (|(s_d.top_flag & ~s_d.top_mask));
      for (int g = 0; g < 2; g++) begin
         pend = pend | (|(s_d.grp_flag[g][GRP_CL +: 2] & ~s_d.grp_mask[g][GRP_CL +: 2]))
            | (|s_d.grp_flag[g][GRP_SC +: 2]) | (|s_d.grp_flag[g][GRP_PG +: 2]);
      end
      s_d.irq_oe = pend;
      s_d.pin    = supplies_ok_valid ^ s_d.pol;
   end

   // State register; the strap is sampled after release, never under reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q           <= '0;
         s_q.st        <= BUS_IDLE;
         s_q.hreadyout <= 1'b1;
         s_q.por_pend  <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register; hresp and irq_out_n_o are tied low
   assign hrdata       = s_q.hrdata;
   assign hreadyout    = s_q.hreadyout;
   assign hresp        = 1'b0;
   assign buck_enable  = s_q.reg_en[0];
   assign lin_enable   = s_q.reg_en[1];
   assign gp_out_a     = s_q.gpa;
   assign gp_out_b     = s_q.gpb;
   assign supplies_ok_pin = s_q.pin;
   assign irq_out_n_o  = 1'b0;  // Open drain only ever pulls low
   assign irq_out_n_oe = s_q.irq_oe;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_buck_cl_hold: assert property (buck_curlim_hit[0] && s_q.grp_flag[0][GRP_CL]
      && !supply_low_lockout && !swrst_wr |=> s_q.grp_flag[0][GRP_CL])
      else $error("buck limit flag cleared while limit active");
   a_lin_cl_hold: assert property (lin_curlim_hit[1] && s_q.grp_flag[1][GRP_CL+1]
      && !supply_low_lockout && !swrst_wr |=> s_q.grp_flag[1][GRP_CL+1])
      else $error("linear limit flag cleared while limit active");
   a_short_disable: assert property ($rose(s_q.grp_flag[0][GRP_SC])
      |-> !buck_enable[0] ##1 !buck_enable[0])
      else $error("buck short flag without disable");
   a_hot_hold: assert property (hot_warning_in && s_q.top_flag[TOP_HOT]
      && !supply_low_lockout && !swrst_wr |=> s_q.top_flag[TOP_HOT])
      else $error("hot warning flag cleared while hot");
   a_trip_kill: assert property (thermal_trip_in |=>
      buck_enable == 2'b00 && lin_enable == 2'b00 && !gp_out_a && !gp_out_b)
      else $error("thermal trip left outputs on");
   a_ovp_flag: assert property (input_overvolt_in && !supply_low_lockout
      && !swrst_wr |=> s_q.top_flag[TOP_OVP] && irq_out_n_oe)
      else $error("overvoltage flag or interrupt missing");
   a_good_rise: assert property (buck_good_in[0] && !s_q.good_prev[0][0]
      && !s_q.grp_mask[0][GRP_RISE] && !supply_low_lockout && !swrst_wr
      |=> s_q.grp_flag[0][GRP_PG])
      else $error("buck good rise not flagged");
   a_pin_polarity: assert property (##1 supplies_ok_pin
      == ($past(supplies_ok_valid) ^ s_q.pol))
      else $error("supplies ok pin polarity wrong");
   a_reset_flag: assert property (s_q.por_pend && !supply_low_lockout
      && !swrst_wr |=> s_q.top_flag[TOP_RST] == !$past(otp_reset_mask))
      else $error("reset flag not set from mask");
   a_irq_pend: assert property ((|s_q.grp_flag[0][GRP_SC +: 2]) |-> irq_out_n_oe)
      else $error("interrupt released with flag pending");
   a_soft_reset: assert property (swrst_wr && !supply_low_lockout
      |=> s_q.por_pend ##1 !s_q.por_pend)
      else $error("soft reset sequence broken");

   c_trip: cover property (thermal_trip_in ##1 !thermal_trip_in);
   c_short: cover property ($rose(s_q.grp_flag[1][GRP_SC]));
   c_reset_flag: cover property ($rose(s_q.top_flag[TOP_RST]));
   c_read: cover property (access && !s_q.wr ##1 hreadyout);

endmodule // pef_event_flags

/* dv/pef_host_model.sv */
// Host model: AHB-Lite master issuing single word transfers
`timescale 1ns/1ps
module pef_host_model (
   // Clock
   input  wire logic        hclk,
   // Bus to the slave
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic      [1:0]  htrans,
   output logic      [31:0] haddr,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata
);
   int n_hang = 0;
   // Bus idle from time zero
   initial begin
      htrans = 2'h0;
      haddr  = 32'h0;
      hwrite = 1'h0;
      hsize  = 3'h2;
      hwdata = 32'h0;
   end
   // Bounded so that a dead slave cannot hang the run
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'h1 && n < 64);
      if (hready !== 1'h1) n_hang++;
   endtask
   // Address phase held until ready, then data phase held until ready
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= w ? d : ~d;
      wait_rdy();
      q = hrdata;
   endtask
endmodule // pef_host_model

/* dv/pmic_event_flag_logic_tb.sv */
// Self-checking bench for the event flag block
`timescale 1ns/1ps
module pmic_event_flag_logic_tb import pef_pkg::*; ;
   localparam int SC = 8;
   logic        hclk, hresetn, hwrite, hrdy, hresp, irq_oe, irq_o, gpa, gpb, ok_pin;
   logic        lockout, ok_valid, sync_in, meas, otp_msk;
   logic [1:0]  htrans, bcl, lcl, bvl, lvl, bgd, lgd, ben, len;
   logic [2:0]  hsize, top_in;
   logic [31:0] haddr, hwdata, hrdata, q;
   wire         irq_line = irq_oe ? 1'h0 : 1'h1; // Pull-up on the shared pin
   int          num_errors = 0;
   int          n_compared = 0;

   pef_event_flags #(.SC_CNT(SC)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
      .hreadyout(hrdy), .hresp(hresp), .buck_curlim_hit(bcl), .lin_curlim_hit(lcl),
      .buck_vout_low(bvl), .lin_vout_low(lvl), .buck_good_in(bgd), .lin_good_in(lgd),
      .hot_warning_in(top_in[0]), .thermal_trip_in(top_in[1]),
      .input_overvolt_in(top_in[2]), .supply_low_lockout(lockout),
      .supplies_ok_valid(ok_valid), .sync_clk_present(sync_in), .load_meas_done(meas),
      .otp_reset_mask(otp_msk), .buck_enable(ben), .lin_enable(len), .gp_out_a(gpa),
      .gp_out_b(gpb), .supplies_ok_pin(ok_pin), .irq_out_n_i(irq_line),
      .irq_out_n_o(irq_o), .irq_out_n_oe(irq_oe));

   pef_host_model host (.hclk(hclk), .hready(hrdy), .hrdata(hrdata), .htrans(htrans),
      .haddr(haddr), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   // 10 MHz clock
   initial begin
      hclk = 1'h0;
      forever #50 hclk = ~hclk;
   end

   task automatic complete_run();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // A hung transfer ends the run at once
   task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d);
      host.xfer(a, w, d, q);
      if (host.n_hang != 0) begin
         num_errors++;
         complete_run();
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xf(a, 1'h0, 32'h0);
      chk(q & m, e);
   endtask
   // Drive one monitor input, then let one edge sample it
   task automatic drv(input int s, input logic v);
      @(posedge hclk);
      case (s)
         0: bcl[1] <= v;
         1: lcl[1] <= v;
         2: bgd[0] <= v;
         3: lgd[0] <= v;
         4: bvl[0] <= v;
         default: lvl[0] <= v;
      endcase
      @(posedge hclk);
   endtask

   task automatic t_reset();
      rdc(ADDR_INT_TOP, 32'h1ff, 32'h40);
      chk(irq_line, 1'h0);
      chk(hresp, 1'h0);
      rdc(8'h40, 32'hffffffff, 32'h0);
      xf(ADDR_MSK_TOP, 1'h1, 32'h40);
      rdc(ADDR_MSK_TOP, 32'h40, 32'h0);
      xf(ADDR_INT_TOP, 1'h1, 32'h40);
      rdc(ADDR_INT_TOP, 32'h1ff, 32'h0);
      chk(irq_line, 1'h1);
      $display("test reset done");
   endtask
   // Current limit on index 1, good edges on index 0
   task automatic t_group(input int lin);
      logic [7:0] ia, ma;
      int         st, sm, gs;
      ia = lin ? ADDR_INT_LIN : ADDR_INT_BUCK;
      ma = lin ? ADDR_MSK_LIN : ADDR_MSK_BUCK;
      st = lin ? ST_LINCL : ST_BUCKCL;
      sm = lin ? TOP_LINSUM : TOP_BUCKSUM;
      gs = lin ? ST_LINPG : ST_BUCKPG;
      drv(lin, 1'h1);
      rdc(ia, 32'h2, 32'h2);
      rdc(ADDR_STAT, 32'h2 << st, 32'h2 << st);
      rdc(ADDR_INT_TOP, 32'h1 << sm, 32'h1 << sm);
      chk(irq_line, 1'h0);
      xf(ia, 1'h1, 32'h2);
      rdc(ia, 32'h2, 32'h2);
      drv(lin, 1'h0);
      xf(ia, 1'h1, 32'h2);
      rdc(ia, 32'h2, 32'h0);
      rdc(ADDR_INT_TOP, 32'h1 << sm, 32'h0);
      xf(ma, 1'h1, 32'h2);
      drv(lin, 1'h1);
      rdc(ia, 32'h2, 32'h0);
      drv(lin, 1'h0);
      drv(2 + lin, 1'h1);
      rdc(ia, 32'h10, 32'h10);
      rdc(ADDR_STAT, 32'h1 << gs, 32'h1 << gs);
      xf(ia, 1'h1, 32'h10);
      xf(ma, 1'h1, 32'h1 << GRP_RISE);
      drv(2 + lin, 1'h0);
      rdc(ia, 32'h10, 32'h10);
      xf(ia, 1'h1, 32'h10);
      drv(2 + lin, 1'h1);
      rdc(ia, 32'h10, 32'h0);
      xf(ma, 1'h1, 32'h1 << GRP_FALL);
      drv(2 + lin, 1'h0);
      rdc(ia, 32'h10, 32'h0);
      xf(ma, 1'h1, 32'h0);
      $display("test group %0d done", lin);
   endtask
   // Warning, trip and overvoltage; only the last two shut outputs down
   task automatic t_top();
      for (int k = 0; k < 3; k++) begin
         xf(ADDR_CTRL, 1'h1, 32'h3f0);
         top_in[k] <= 1'h1;
         cyc(2);
         chk({gpb, gpa, len, ben}, k == 0 ? 6'h3f : 6'h00);
         rdc(ADDR_INT_TOP, 32'h1 << k, 32'h1 << k);
         rdc(ADDR_STAT, 32'h1 << k, 32'h1 << k);
         xf(ADDR_INT_TOP, 1'h1, 32'h1 << k);
         rdc(ADDR_INT_TOP, 32'h1 << k, 32'h1 << k);
         top_in[k] <= 1'h0;
         cyc(1);
         xf(ADDR_INT_TOP, 1'h1, 32'h1 << k);
         rdc(ADDR_INT_TOP, 32'h1 << k, 32'h0);
      end
      xf(ADDR_CTRL, 1'h1, 32'h0);
      $display("test top events done");
   endtask
   task automatic t_short();
      for (int lin = 0; lin < 2; lin++) begin
         drv(4 + lin, 1'h1);
         xf(ADDR_CTRL, 1'h1, lin ? 32'h40 : 32'h10);
         chk(lin ? len[0] : ben[0], 1'h1);
         cyc(SC + 4);
         chk(lin ? len[0] : ben[0], 1'h0);
         rdc(lin ? ADDR_INT_LIN : ADDR_INT_BUCK, 32'h4, 32'h4);
         drv(4 + lin, 1'h0);
         xf(lin ? ADDR_INT_LIN : ADDR_INT_BUCK, 1'h1, 32'h4);
         rdc(lin ? ADDR_INT_LIN : ADDR_INT_BUCK, 32'h4, 32'h0);
         // Debounce: output drops after the start-up check, trips SC cycles later
         xf(ADDR_CTRL, 1'h1, lin ? 32'h40 : 32'h10);
         cyc(SC + 2);
         drv(4 + lin, 1'h1);
         cyc(SC - 2);
         chk(lin ? len[0] : ben[0], 1'h1);
         cyc(4);
         chk(lin ? len[0] : ben[0], 1'h0);
         rdc(lin ? ADDR_INT_LIN : ADDR_INT_BUCK, 32'h4, 32'h4);
         drv(4 + lin, 1'h0);
         xf(lin ? ADDR_INT_LIN : ADDR_INT_BUCK, 1'h1, 32'h4);
      end
      xf(ADDR_CTRL, 1'h1, 32'h0);
      $display("test short done");
   endtask
   task automatic t_ok();
      ok_valid <= 1'h1;
      cyc(2);
      chk(ok_pin, 1'h1);
      rdc(ADDR_INT_TOP, 32'h8, 32'h0);
      xf(ADDR_CTRL, 1'h1, 32'h2);
      chk(ok_pin, 1'h0);
      rdc(ADDR_STAT, 32'h8, 32'h8);
      ok_valid <= 1'h0;
      cyc(2);
      chk(ok_pin, 1'h1);
      rdc(ADDR_INT_TOP, 32'h8, 32'h8);
      xf(ADDR_INT_TOP, 1'h1, 32'h8);
      xf(ADDR_CTRL, 1'h1, 32'h0);
      $display("test supplies ok done");
   endtask
   task automatic t_sync();
      for (int v = 1; v >= 0; v--) begin
         sync_in <= v[0];
         cyc(2);
         rdc(ADDR_STAT, 32'h10, v ? 32'h10 : 32'h0);
         rdc(ADDR_INT_TOP, 32'h10, 32'h10);
         xf(ADDR_INT_TOP, 1'h1, 32'h10);
      end
      rdc(ADDR_INT_TOP, 32'h10, 32'h0);
      xf(ADDR_CTRL, 1'h1, 32'h4);
      rdc(ADDR_INT_TOP, 32'h10, 32'h10);
      xf(ADDR_CTRL, 1'h1, 32'h0);
      xf(ADDR_INT_TOP, 1'h1, 32'h10);
      for (int m = 0; m < 2; m++) begin
         xf(ADDR_MSK_TOP, 1'h1, m ? 32'h20 : 32'h0);
         meas <= 1'h1;
         @(posedge hclk);
         meas <= 1'h0;
         rdc(ADDR_INT_TOP, 32'h20, m ? 32'h0 : 32'h20);
         xf(ADDR_INT_TOP, 1'h1, 32'h20);
      end
      xf(ADDR_MSK_TOP, 1'h1, 32'h0);
      $display("test sync and measure done");
   endtask
   // Soft reset, then lockout with each reset-mask setting
   task automatic t_restart();
      xf(ADDR_CTRL, 1'h1, 32'h11);
      chk(ben, 2'h0);
      rdc(ADDR_CTRL, 32'hffffffff, 32'h0);
      rdc(ADDR_INT_TOP, 32'h40, 32'h40);
      for (int o = 0; o < 2; o++) begin
         otp_msk <= o[0];
         lockout <= 1'h1;
         cyc(3);
         chk(irq_line, 1'h1);
         rdc(ADDR_INT_TOP, 32'h1ff, 32'h0);
         lockout <= 1'h0;
         cyc(2);
         rdc(ADDR_INT_TOP, 32'h40, o ? 32'h0 : 32'h40);
         rdc(ADDR_MSK_TOP, 32'h40, o ? 32'h40 : 32'h0);
      end
      $display("test restart done");
   endtask

   // Main sequence
   initial begin
      hresetn = 1'h0;
      {bcl, lcl, bvl, lvl, bgd, lgd} = 12'h0;
      {top_in, lockout, ok_valid, sync_in, meas, otp_msk} = 8'h0;
      cyc(16);
      hresetn <= 1'h1;
      t_reset();
      t_group(0);
      t_group(1);
      t_top();
      t_short();
      t_ok();
      t_sync();
      t_restart();
      complete_run();
   end
   // Watchdog against a hang
   initial begin
      repeat (100000) @(posedge hclk);
      num_errors++;
      complete_run();
   end
endmodule // pmic_event_flag_logic_tb
